// [acs_sequencer.sv]
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
// Behaviour
// (RQ1) software calibration starts only by a control write with the launch bit set
// (RQ2) full, gain+offset, single calibrations take fixed master clock counts
// (RQ3) first convert-start after power-on starts a 32 ms settling timeout
// (RQ4) that convert-start raises busy; busy falls once the timeout elapsed
// (RQ5) next convert-start runs auto full calibration; conversions follow
// (RQ6) convert-start pulses are ignored while busy is high
// (RQ7) control write before the auto calibration launches cancels it
// (RQ8) write during timeout keeps busy full length; next pulse converts
// (RQ9) control write during auto calibration does not abort it
// (RQ10) host should cancel auto calibration early with on-chip reference
// (RQ11) ready 5 us after waking from software power-down
// (RQ12) host picks partial power-down last if off beyond 100 ms
// (RQ13) power-down-after-conversion modes power only wake and conversion
// (RQ14) host recalibrates only when operating conditions change
// (RQ15) convert-start fall wakes, rise converts; host holds low 5 us
// (RQ16) power field: 00 normal, 01 off after, 10 off, 11 partial after
// (RQ17) software calibration raises busy at write end, drops it when done
// (RQ18) intervals are counted in master clock cycles; the wake-up interval is counted in clk cycles instead
module acs_sequencer
  import acs_pkg::*;
#(
  parameter int TW            = 17,
  parameter int TIMEOUT_CYC   = int'(TIMEOUT_MCLK),
  parameter int CAL_FULL_CYC  = int'(CAL_FULL_MCLK),
  parameter int CAL_GO_CYC    = int'(CAL_GO_MCLK),
  parameter int CAL_ONE_CYC   = int'(CAL_ONE_MCLK)
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         clk_en,
  input  wire acs_apb_req_t apb_req,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         master_clock_input,
  input  wire logic         convert_start_n,
  output logic              busy,
  output logic              irq,
  output logic              conv_active,
  output logic              full_power_down,
  output logic              reference_on
);

  // register group
  acs_ctrl_t        ctrl_reg,      ctrl_next;
  logic [IRQ_W-1:0] irq_stat_reg,  irq_stat_next;
  logic [IRQ_W-1:0] irq_mask_reg,  irq_mask_next;
  logic [31:0]      prdata_reg,    prdata_next;
  logic             pready_reg,    pready_next;
  logic             pslverr_reg,   pslverr_next;
  logic             irq_reg,       irq_next;

  // sequencer group
  acs_state_t       state_reg,     state_next;
  logic             autocal_reg,   autocal_next;
  logic             powered_reg,   powered_next;
  logic             busy_reg,      busy_next;
  logic             conv_reg,      conv_next;
  logic             fullpd_reg,    fullpd_next;
  logic             refon_reg,     refon_next;

  // helpers
  logic [1:0]       rise;
  logic [1:0]       fall;
  logic             mt_load;
  logic [TW-1:0]    mt_value;
  logic             mt_done;
  logic             wk_load;
  logic             wk_running;
  logic             wk_done;
  logic             acc_wr;
  logic             wr_ctrl;
  logic             launch;
  logic             conv_rise;
  logic             conv_fall;
  logic [IRQ_W-1:0] events;
  acs_ctrl_t        wr_fields;

  // interval length for each calibration type
  function automatic logic [TW-1:0] cal_cycles(input acs_cal_t t);
    case (t)
      CAL_FULL:    cal_cycles = TW'(CAL_FULL_CYC); // RQ2
      CAL_GAIN_OF: cal_cycles = TW'(CAL_GO_CYC); // RQ2
      default:     cal_cycles = TW'(CAL_ONE_CYC); // RQ2
    endcase
  endfunction

  // true for states that hold busy high
  function automatic logic is_busy(input acs_state_t s);
    is_busy = (s == ST_TIMEOUT) || (s == ST_AUTO_CAL) || (s == ST_WAKE) ||
              (s == ST_CONVERT) || (s == ST_SW_CAL);
  endfunction

  // edges of convert-start (bit 0) and master clock (bit 1)
  acs_edge_detect #(
    .N    (2),
    .IDLE (EDGE_IDLE)
  ) u_edges (
    .clk      (clk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .level_in ({master_clock_input, convert_start_n}),
    .rise     (rise),
    .fall     (fall)
  );

  // timeout, calibration and conversion timer in master clock cycles
  acs_interval_timer #(
    .TW (TW)
  ) u_mclk_timer (
    .clk        (clk),
    .reset_n    (reset_n),
    .clk_en     (clk_en),
    .load       (mt_load),
    .load_value (mt_value),
    .tick       (rise[1]), // RQ18
    .running    (),
    .done       (mt_done)
  );

  // wake-up timer in system clock cycles
  acs_interval_timer #(
    .TW (TW)
  ) u_wake_timer (
    .clk        (clk),
    .reset_n    (reset_n),
    .clk_en     (clk_en),
    .load       (wk_load),
    .load_value (TW'(WAKE_CLKS)),
    .tick       (1'b1),
    .running    (wk_running),
    .done       (wk_done)
  );

  // bus decode; a write takes effect at the access edge with pready high
  assign acc_wr    = clk_en & apb_req.psel & apb_req.penable &
                     apb_req.pwrite & pready_reg;
  assign wr_ctrl   = acc_wr & (apb_req.paddr == CTRL_OFS);
  assign launch    = wr_ctrl & apb_req.pwdata[CTRL_LAUNCH_BIT]; // RQ1
  assign wr_fields = apb_req.pwdata[CTRL_PM_LSB+1:CTRL_TYPE_LSB];
  // convert-start pulse acts at its falling and rising edges, both masked when busy
  assign conv_rise = rise[0] & ~busy_reg; // RQ6
  assign conv_fall = fall[0] & ~busy_reg; // RQ6

  // sequencer next state
  always_comb begin
    state_next   = state_reg;
    autocal_next = autocal_reg;
    powered_next = powered_reg;
    mt_load      = 1'b0;
    mt_value     = TW'(CONV_MCLK);
    wk_load      = 1'b0;
    events       = '0;
    if (clk_en) begin
      if (wk_done) begin
        powered_next = 1'b1; // RQ11
      end
      case (state_reg)
        ST_PWR_IDLE: begin
          if (wr_ctrl) begin
            autocal_next = 1'b0; // RQ7
            state_next   = ST_READY;
            if (launch) begin
              mt_load    = 1'b1;
              mt_value   = cal_cycles(wr_fields.cal);
              state_next = ST_SW_CAL; // RQ17
            end
          end else if (conv_rise) begin
            mt_load    = 1'b1;
            mt_value   = TW'(TIMEOUT_CYC); // RQ3
            state_next = ST_TIMEOUT; // RQ4
          end
        end
        ST_TIMEOUT: begin
          if (wr_ctrl) begin
            autocal_next = 1'b0; // RQ8
          end
          if (mt_done) begin
            events[IRQ_TIMEOUT_BIT] = 1'b1;
            state_next = (autocal_reg && !wr_ctrl) ? ST_AUTO_WAIT
                                                   : ST_READY; // RQ8
          end
        end
        ST_AUTO_WAIT: begin
          if (wr_ctrl) begin
            autocal_next = 1'b0; // RQ7
            state_next   = ST_READY;
            if (launch) begin
              mt_load    = 1'b1;
              mt_value   = cal_cycles(wr_fields.cal);
              state_next = ST_SW_CAL; // RQ17
            end
          end else if (conv_rise) begin
            autocal_next = 1'b0;
            mt_load      = 1'b1;
            mt_value     = TW'(CAL_FULL_CYC);
            state_next   = ST_AUTO_CAL; // RQ5
          end
        end
        ST_AUTO_CAL: begin
          // control writes only update fields here
          if (mt_done) begin // RQ9
            events[IRQ_CAL_BIT] = 1'b1;
            state_next = ST_READY; // RQ5
          end
        end
        ST_READY: begin
          if (launch) begin
            powered_next = 1'b1;
            mt_load      = 1'b1;
            mt_value     = cal_cycles(wr_fields.cal);
            state_next   = ST_SW_CAL; // RQ17
          end else if (ctrl_reg.pm == PM_FULL_PD) begin
            powered_next = 1'b0; // RQ16
          end else if (conv_rise) begin
            if (powered_reg) begin
              mt_load    = 1'b1;
              state_next = ST_CONVERT; // RQ5
            end else begin
              wk_load    = !wk_running;
              state_next = ST_WAKE; // RQ15
            end
          end else if (conv_fall && !powered_reg && !wk_running) begin
            wk_load = 1'b1; // RQ15
          end else if (ctrl_reg.pm == PM_NORMAL && !powered_reg &&
                       !wk_running) begin
            wk_load = 1'b1; // RQ11
          end
        end
        ST_WAKE: begin
          if (wk_done) begin
            mt_load    = 1'b1;
            state_next = ST_CONVERT; // RQ11
          end
        end
        ST_CONVERT: begin
          if (mt_done) begin
            events[IRQ_CONV_BIT] = 1'b1;
            state_next = ST_READY;
            if (ctrl_reg.pm == PM_PD_AFTER ||
                ctrl_reg.pm == PM_PART_AFTER) begin
              powered_next = 1'b0; // RQ13
            end
          end
        end
        ST_SW_CAL: begin
          if (mt_done) begin
            events[IRQ_CAL_BIT] = 1'b1;
            state_next = ST_READY; // RQ17
          end
        end
        default: begin
          state_next = ST_PWR_IDLE;
        end
      endcase
    end
  end

  // registered outputs follow the next state
  always_comb begin
    busy_next   = is_busy(state_next); // RQ4
    conv_next   = (state_next == ST_CONVERT);
    fullpd_next = !powered_next && ctrl_reg.pm != PM_PART_AFTER; // RQ16
    refon_next  = powered_next || ctrl_reg.pm == PM_PART_AFTER; // RQ16
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg   <= ST_PWR_IDLE;
      autocal_reg <= 1'b1;
      powered_reg <= 1'b1;
      busy_reg    <= 1'b0;
      conv_reg    <= 1'b0;
      fullpd_reg  <= 1'b0;
      refon_reg   <= 1'b1;
    end else begin
      state_reg   <= state_next;
      autocal_reg <= autocal_next;
      powered_reg <= powered_next;
      busy_reg    <= busy_next;
      conv_reg    <= conv_next;
      fullpd_reg  <= fullpd_next;
      refon_reg   <= refon_next;
    end
  end

  // register file, bus answer and interrupt
  always_comb begin
    ctrl_next     = ctrl_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    prdata_next   = prdata_reg;
    pready_next   = pready_reg;
    pslverr_next  = pslverr_reg;
    irq_next      = irq_reg;
    if (clk_en) begin
      // no wait state: answer prepared during the setup cycle
      pready_next  = apb_req.psel & ~apb_req.penable;
      pslverr_next = 1'b0;
      prdata_next  = '0;
      if (apb_req.psel && !apb_req.penable) begin
        case (apb_req.paddr)
          CTRL_OFS:     prdata_next[CTRL_PM_LSB+1:CTRL_TYPE_LSB] = ctrl_reg;
          STAT_OFS:     prdata_next[6:0] = {autocal_reg, powered_reg,
                                            state_reg, busy_reg};
          IRQ_STAT_OFS: prdata_next[IRQ_W-1:0] = irq_stat_reg;
          IRQ_MASK_OFS: prdata_next[IRQ_W-1:0] = irq_mask_reg;
          default:      pslverr_next = 1'b1;
        endcase
      end
      if (wr_ctrl) begin
        ctrl_next = wr_fields; // RQ1
      end
      if (acc_wr && apb_req.paddr == IRQ_MASK_OFS) begin
        irq_mask_next = apb_req.pwdata[IRQ_W-1:0];
      end
      // write one to clear; a same-cycle event wins
      if (acc_wr && apb_req.paddr == IRQ_STAT_OFS) begin
        irq_stat_next = irq_stat_reg & ~apb_req.pwdata[IRQ_W-1:0];
      end
      irq_stat_next = irq_stat_next | events;
      irq_next      = |(irq_stat_next & irq_mask_next);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_reg     <= '0;
      irq_stat_reg <= '0;
      irq_mask_reg <= IRQ_MASK_RST;
      prdata_reg   <= '0;
      pready_reg   <= 1'b0;
      pslverr_reg  <= 1'b0;
      irq_reg      <= 1'b0;
    end else begin
      ctrl_reg     <= ctrl_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      prdata_reg   <= prdata_next;
      pready_reg   <= pready_next;
      pslverr_reg  <= pslverr_next;
      irq_reg      <= irq_next;
    end
  end

  assign prdata          = prdata_reg;
  assign pready          = pready_reg;
  assign pslverr         = pslverr_reg;
  assign busy            = busy_reg;
  assign irq             = irq_reg;
  assign conv_active     = conv_reg;
  assign full_power_down = fullpd_reg;
  assign reference_on    = refon_reg;

endmodule

// [acs_pkg.sv]
package acs_pkg;

  // apb register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STAT_OFS     = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;

  // control register field positions
  localparam int CTRL_LAUNCH_BIT = 0;
  localparam int CTRL_TYPE_LSB   = 1;
  localparam int CTRL_SYS_BIT    = 3;
  localparam int CTRL_PM_LSB     = 4;

  // interrupt status bit positions
  localparam int IRQ_TIMEOUT_BIT = 0;
  localparam int IRQ_CAL_BIT     = 1;
  localparam int IRQ_CONV_BIT    = 2;
  localparam int IRQ_W           = 3;

  // values after reset
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic [1:0]       EDGE_IDLE    = 2'h1;

  // clock rates
  localparam longint MCLK_KHZ = 4000;
  localparam longint CLK_MHZ  = 200;

  // times as specified, in ns
  localparam longint T_TIMEOUT_NS  = 32000000;
  localparam longint T_CAL_FULL_NS = 31250000;
  localparam longint T_CAL_GO_NS   = 6940000;
  localparam longint T_CAL_ONE_NS  = 3470000;
  localparam longint T_CONV_NS     = 4600;
  localparam longint T_WAKE_NS     = 5000;

  // derived counts: master clock cycles, or clk cycles for the wake-up
  localparam longint TIMEOUT_MCLK  = T_TIMEOUT_NS * MCLK_KHZ / 1000000;
  localparam longint CAL_FULL_MCLK = T_CAL_FULL_NS * MCLK_KHZ / 1000000;
  localparam longint CAL_GO_MCLK   = T_CAL_GO_NS * MCLK_KHZ / 1000000;
  localparam longint CAL_ONE_MCLK  = T_CAL_ONE_NS * MCLK_KHZ / 1000000;
  localparam longint CONV_MCLK     = T_CONV_NS * MCLK_KHZ / 1000000;
  localparam longint WAKE_CLKS     = (T_WAKE_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    PM_NORMAL     = 2'b00,
    PM_PD_AFTER   = 2'b01,
    PM_FULL_PD    = 2'b10,
    PM_PART_AFTER = 2'b11
  } acs_pm_t;

  typedef enum logic [1:0] {
    CAL_FULL    = 2'b00,
    CAL_GAIN_OF = 2'b01,
    CAL_OFFSET  = 2'b10,
    CAL_GAIN    = 2'b11
  } acs_cal_t;

  typedef enum logic [3:0] {
    ST_PWR_IDLE  = 4'b0000,
    ST_TIMEOUT   = 4'b0001,
    ST_AUTO_WAIT = 4'b0010,
    ST_AUTO_CAL  = 4'b0011,
    ST_READY     = 4'b0100,
    ST_WAKE      = 4'b0101,
    ST_CONVERT   = 4'b0110,
    ST_SW_CAL    = 4'b0111
  } acs_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } acs_apb_req_t;

  typedef struct packed {
    acs_pm_t  pm;
    logic     sys;
    acs_cal_t cal;
  } acs_ctrl_t;

endpackage

// [acs_edge_detect.sv]
`timescale 1ns/100ps
module acs_edge_detect #(
  parameter int           N    = 2,
  parameter logic [N-1:0] IDLE = '0
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         clk_en,
  input  wire logic [N-1:0] level_in,
  output logic      [N-1:0] rise,
  output logic      [N-1:0] fall
);

  logic [N-1:0] prev_reg;
  logic [N-1:0] prev_next;

  // one edge detector per input line
  for (genvar i = 0; i < N; i++) begin : g_edge
    assign rise[i]      = clk_en & level_in[i] & ~prev_reg[i];
    assign fall[i]      = clk_en & ~level_in[i] & prev_reg[i];
    assign prev_next[i] = clk_en ? level_in[i] : prev_reg[i];
  end

  // previous level, idle value after reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prev_reg <= IDLE;
    end else begin
      prev_reg <= prev_next;
    end
  end

endmodule

// [acs_interval_timer.sv]
`timescale 1ns/100ps
module acs_interval_timer #(
  parameter int TW = 17
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          clk_en,
  input  wire logic          load,
  input  wire logic [TW-1:0] load_value,
  input  wire logic          tick,
  output logic               running,
  output logic               done
);

  logic [TW-1:0] cnt_reg;
  logic [TW-1:0] cnt_next;
  logic          done_reg;
  logic          done_next;

  // count down one per tick; done pulses after the last tick
  always_comb begin
    cnt_next  = cnt_reg;
    done_next = 1'b0;
    if (clk_en) begin
      if (load) begin
        cnt_next = load_value;
      end else if (tick && cnt_reg != '0) begin
        cnt_next  = cnt_reg - TW'(1);
        done_next = (cnt_reg == TW'(1));
      end
    end else begin
      done_next = done_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign running = (cnt_reg != '0);
  assign done    = done_reg & clk_en;

endmodule

// [acs_host_model.sv]
`timescale 1ns/100ps
// host side: free master clock and active-low convert-start pulses
module acs_host_model (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [10:0] low_len,
  output logic             master_clock_input,
  output logic             convert_start_n
);
  logic [1:0]  div_reg  = 2'h0;
  logic [10:0] hold_reg = 11'h000;

  initial begin
    master_clock_input = 1'b0;
    convert_start_n    = 1'b1;
  end

  // master clock at one eighth of clk, running all the time
  always @(posedge clk) begin
    div_reg <= div_reg + 2'h1;
    if (div_reg == 2'h3) begin
      master_clock_input <= ~master_clock_input;
    end
  end

  // pin held low for the whole requested width before it rises
  always @(posedge clk) begin
    if (go) begin
      convert_start_n <= 1'b0;
      hold_reg        <= low_len - 11'h001;
    end else if (hold_reg != 11'h000) begin
      hold_reg <= hold_reg - 11'h001;
    end else begin
      convert_start_n <= 1'b1;
    end
  end
endmodule

// [acs_seq_chk.sv]
`timescale 1ns/100ps
module acs_seq_chk
  import acs_pkg::*;
#(
  parameter int TIMEOUT_CYC = 20
) (
  input wire logic         clk,
  input wire logic         reset_n,
  input wire logic         clk_en,
  input wire acs_apb_req_t apb_req,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic         master_clock_input,
  input wire logic         convert_start_n,
  input wire logic         busy,
  input wire logic         irq,
  input wire logic         conv_active,
  input wire logic         full_power_down,
  input wire logic         reference_on
);
  // generous ceiling: master clock no slower than clk/64, plus wake
  localparam int BUSY_MAX = 64 * TIMEOUT_CYC + 1500;
  int busy_cnt_reg;
  int busy_cnt_next;

  // length of the running busy interval in clk cycles
  always_comb begin
    busy_cnt_next = busy ? busy_cnt_reg + 1 : 0;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy_cnt_reg <= 0;
    end else begin
      busy_cnt_reg <= busy_cnt_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_pready_pulse; pready |=> !pready; endproperty
  a_pready_pulse: assert property (p_pready_pulse)
    else $error("pready stood more than one cycle");
  property p_pready_access;
    pready |-> apb_req.psel && apb_req.penable;
  endproperty
  a_pready_access: assert property (p_pready_access)
    else $error("pready outside an access phase");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("pslverr without pready");
  property p_start_busy;
    !busy && !full_power_down && clk_en && $rose(convert_start_n)
      |-> ##[1:3] busy;
  endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("convert-start rise did not raise busy");
  property p_sw_cal;
    pready && apb_req.pwrite && apb_req.paddr == CTRL_OFS
      && apb_req.pwdata[CTRL_LAUNCH_BIT] && !busy |-> ##[1:2] busy;
  endproperty
  a_sw_cal: assert property (p_sw_cal)
    else $error("launch write did not raise busy");
  property p_busy_min; $rose(busy) |=> busy [*8]; endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("busy interval too short");
  property p_busy_max; busy_cnt_reg <= BUSY_MAX; endproperty
  a_busy_max: assert property (p_busy_max)
    else $error("busy interval too long");
  // idle write of mode 10 powers everything down two edges later
  property p_pm_full;
    clk_en && pready && apb_req.pwrite && apb_req.paddr == CTRL_OFS
      && apb_req.pwdata[CTRL_PM_LSB +: 2] == PM_FULL_PD
      && !apb_req.pwdata[CTRL_LAUNCH_BIT] && !busy
      && !$rose(convert_start_n) |-> ##2 full_power_down && !reference_on;
  endproperty
  a_pm_full: assert property (p_pm_full)
    else $error("reference on during full power-down");
  // a conversion runs busy and fully powered
  property p_conv_busy;
    conv_active |-> busy && reference_on && !full_power_down;
  endproperty
  a_conv_busy: assert property (p_conv_busy)
    else $error("conversion without busy");
endmodule

bind acs_sequencer acs_seq_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
  .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .apb_req(apb_req),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .master_clock_input(master_clock_input),
  .convert_start_n(convert_start_n), .busy(busy), .irq(irq),
  .conv_active(conv_active), .full_power_down(full_power_down),
  .reference_on(reference_on)
);

// [tb_top.sv]
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  $display("BAD %s exp %0h got %0h", n, e, g); fail_count++; end end
module tb_top;
  import acs_pkg::*;
  localparam int TO = 20;
  localparam int CF = 16;
  logic         clk, reset_n, clk_en, go, mclk, cs_n, pready, pslverr;
  logic         busy, irq, conv_active, fpd, ref_on, bprev, mprev;
  logic [10:0]  low_len;
  logic [31:0]  prdata;
  logic [33:0]  apb_x;
  acs_apb_req_t req;
  int           fail_count, samples_checked, cycles, cnt;
  int           cal_len[4] = '{CF, 8, 4, 4};
  logic [33:0]  apb_q[$];
  int           lo_q[$];
  int           hi_q[$];

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  acs_sequencer #(.TIMEOUT_CYC(TO), .CAL_FULL_CYC(CF), .CAL_GO_CYC(8),
    .CAL_ONE_CYC(4)) DUT (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_clock_input(mclk), .convert_start_n(cs_n), .busy(busy),
    .irq(irq), .conv_active(conv_active), .full_power_down(fpd),
    .reference_on(ref_on));
  acs_host_model host (.clk(clk), .go(go), .low_len(low_len),
    .master_clock_input(mclk), .convert_start_n(cs_n));

  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // one apb transfer; the expected answer is noted for the monitor
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [31:0] e, input logic er);
    apb_q.push_back({!w, er, e});
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task pulse(input int len);
    @(posedge clk);
    go <= 1'b1;
    low_len <= 11'(len);
    @(posedge clk);
    go <= 1'b0;
    repeat (len + 2) @(posedge clk);
  endtask
  task exp_busy(input int n, input int w);
    lo_q.push_back(n - w);
    hi_q.push_back(n + w);
  endtask
  task wait_idle;
    repeat (4) @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
  task do_reset;
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
  endtask

  // monitor: bus answers and busy lengths in master clock rises
  always @(posedge clk) begin
    mprev <= mclk;
    bprev <= busy;
    if (pready === 1'b1 && apb_q.size() > 0) begin
      apb_x = apb_q.pop_front();
      `CHK("pslverr", apb_x[32], pslverr)
      if (apb_x[33]) `CHK("prdata", apb_x[31:0], prdata)
    end
    if (reset_n !== 1'b1) cnt = 0;
    else begin
      if (busy === 1'b1 && mclk && !mprev) cnt++;
      if (bprev === 1'b1 && busy === 1'b0) begin
        `CHK("busy_len", 1'b1, cnt >= lo_q[0] && cnt <= hi_q[0])
        void'(lo_q.pop_front());
        void'(hi_q.pop_front());
      end
      if (busy !== 1'b1) cnt = 0;
    end
  end

  // cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    go = 1'b0;
    low_len = 11'h000;
    req = '0;
    fail_count = 0;
    samples_checked = 0;
    cycles = 0;
    cnt = 0;
    void'($urandom(90582));
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    // reset values and an unmapped place
    apb(1'b0, STAT_OFS, 32'h0, 32'h00000060, 1'b0);
    apb(1'b0, IRQ_MASK_OFS, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
    apb(1'b1, IRQ_MASK_OFS, 32'h00000004, 32'h0, 1'b0);
    // timeout with an ignored pulse, auto calibration, first conversion
    exp_busy(TO + 5, 1);
    pulse(3 + $urandom % 8);
    repeat (30) @(posedge clk);
    pulse(4);
    // frozen clock enable: five master clock rises go uncounted
    clk_en <= 1'b0;
    repeat (40) @(posedge clk);
    clk_en <= 1'b1;
    wait_idle;
    exp_busy(CF, 1);
    pulse(3 + $urandom % 8);
    repeat (30) @(posedge clk);
    apb(1'b1, CTRL_OFS, 32'h0, 32'h0, 1'b0);
    `CHK("cal_conv", 1'b0, conv_active)
    wait_idle;
    exp_busy(18, 1);
    pulse(3 + $urandom % 8);
    wait_idle;
    `CHK("irq_set", 1'b1, irq)
    apb(1'b0, IRQ_STAT_OFS, 32'h0, 32'h00000007, 1'b0);
    apb(1'b1, IRQ_STAT_OFS, 32'h00000007, 32'h0, 1'b0);
    apb(1'b0, IRQ_STAT_OFS, 32'h0, 32'h0, 1'b0);
    `CHK("irq_clr", 1'b0, irq)
    // control write in mid-timeout: full timeout, then a conversion
    do_reset;
    exp_busy(TO, 1);
    pulse(5);
    repeat (20) @(posedge clk);
    apb(1'b1, CTRL_OFS, 32'h0, 32'h0, 1'b0);
    wait_idle;
    exp_busy(18, 1);
    pulse(5);
    wait_idle;
    // early write cancels auto calibration; every calibration type
    do_reset;
    apb(1'b1, CTRL_OFS, 32'h0, 32'h0, 1'b0);
    exp_busy(18, 1);
    pulse(6);
    wait_idle;
    for (int t = 0; t < 4; t++) begin
      exp_busy(cal_len[t], 1);
      apb(1'b1, CTRL_OFS, 32'h1 | (32'(t) << CTRL_TYPE_LSB)
          | (32'($urandom % 2) << CTRL_SYS_BIT), 32'h0, 1'b0);
      wait_idle;
    end
    // power-down after conversion, wake, partial and full power-down
    apb(1'b1, CTRL_OFS, 32'(PM_PD_AFTER) << CTRL_PM_LSB, 32'h0, 1'b0);
    exp_busy(18, 1);
    pulse(5);
    `CHK("conv_on", 1'b1, conv_active)
    wait_idle;
    `CHK("pd_after", 2'b10, {fpd, ref_on})
    exp_busy(140, 5);
    pulse(20);
    wait_idle;
    apb(1'b1, CTRL_OFS, 32'(PM_PART_AFTER) << CTRL_PM_LSB, 32'h0, 1'b0);
    repeat (2) @(posedge clk);
    `CHK("pd_part", 2'b01, {fpd, ref_on})
    apb(1'b1, CTRL_OFS, 32'(PM_FULL_PD) << CTRL_PM_LSB, 32'h0, 1'b0);
    repeat (2) @(posedge clk);
    `CHK("pd_full", 2'b10, {fpd, ref_on})
    pulse(5);
    `CHK("pd_busy", 1'b0, busy)
    // back to normal mode: software wake-up takes 5 us
    apb(1'b1, CTRL_OFS, 32'h0, 32'h0, 1'b0);
    repeat (900) @(posedge clk);
    `CHK("wake_early", 2'b10, {fpd, ref_on})
    repeat (105) @(posedge clk);
    `CHK("wake_done", 2'b01, {fpd, ref_on})
    `CHK("left", 0, lo_q.size() + apb_q.size())
    stop_test();
  end
endmodule
